// *** rtl/pcr_consts.svh ***
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
`define PCR_DEV_ADDR        6'o67
`define PCR_SUB_SKIP        6'o01
`define PCR_SUB_READ        6'o12
`define PCR_SUB_SEL_ALPHA   6'o04
`define PCR_SUB_SEL_BIN     6'o14
`define PCR_COLUMNS         7'd80
`define PCR_CLK_PERIOD_PS   4000
`define PCR_COL_PERIOD_NS   2300000
// divide the period down first: scaling 2.3 ms up to picoseconds overflows a 32-bit int
`define PCR_COL_CYCLES      (`PCR_COL_PERIOD_NS / (`PCR_CLK_PERIOD_PS / 1000))
`define PCR_READ_WIN_NS     300000
`define PCR_READ_WIN_CYCLES (`PCR_READ_WIN_NS / (`PCR_CLK_PERIOD_PS / 1000))
`define PCR_ACC_LSB         5'd12
`define PCR_ST_FLAG         9
`define PCR_ST_DONE         10
`define PCR_ST_FAULT        11
`define PCR_ST_EOF          12
`endif

// *** rtl/pcr_pkg.sv ***
`default_nettype none
package pcr_pkg;
	typedef enum logic [1:0]
	{
		PCR_IDLE = 2'b00,
		PCR_FEED = 2'b01,
		PCR_DONE = 2'b11
	} pcr_state_t;
	typedef enum logic
	{
		PCR_MODE_ALPHA = 1'b0,
		PCR_MODE_BIN   = 1'b1
	} pcr_mode_t;
endpackage
`default_nettype wire

// *** rtl/pcr_col_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pcr_col_if;
	logic        strobe;
	logic [11:0] rows;
	logic [5:0]  alpha;
	modport src (output strobe, output rows, output alpha);
	modport dst (input strobe, input rows, input alpha);
endinterface
`default_nettype wire

// *** rtl/pcr_col_pacer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.svh"
module pcr_col_pacer
	import pcr_pkg::*;
#(
	parameter int COL_CYCLES = `PCR_COL_CYCLES
)
(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        start_i,
	input  wire logic [11:0] rows_i,
	input  wire logic [5:0]  alpha_i,
	output logic             busy_o,
	pcr_col_if.src           col
);
	logic [31:0] tick_reg;
	logic [6:0]  count_reg;
	logic        busy_reg;
	logic        strobe_reg;
	logic [11:0] rows_reg;
	logic [5:0]  alpha_reg;
	assign busy_o = busy_reg;
	assign col.strobe = strobe_reg;
	assign col.rows = rows_reg;
	assign col.alpha = alpha_reg;
	// reader mechanism paces columns; host cannot stall it
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tick_reg <= 32'h0;
			count_reg <= 7'h0;
			busy_reg <= 1'b0;
			strobe_reg <= 1'b0;
		end
		else
		begin
			strobe_reg <= 1'b0;
			if (!busy_reg)
			begin
				if (start_i)
				begin
					busy_reg <= 1'b1;
					count_reg <= 7'h0;
					tick_reg <= 32'(COL_CYCLES - 1);
				end
			end
			else if (tick_reg == 32'h0)
			begin
				strobe_reg <= 1'b1; // RULE2
				tick_reg <= 32'(COL_CYCLES - 1);
				count_reg <= count_reg + 7'h1;
				if (count_reg == `PCR_COLUMNS - 7'h1)
					busy_reg <= 1'b0; // RULE1
			end
			else
				tick_reg <= tick_reg - 32'h1;
		end
	end
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rows_reg <= 12'h000;
			alpha_reg <= 6'h00;
		end
		else if (busy_reg && tick_reg == 32'h0)
		begin
			rows_reg <= rows_i;
			alpha_reg <= alpha_i;
		end
	end
endmodule
`default_nettype wire

// *** rtl/pcr_card_reader.sv ***
// Function
// RULE1 - one select delivers all 80 columns in order, paced by reader
// RULE2 - column-ready flag set per new column, columns 2.3 ms apart
// RULE3 - host must read within 300 us of flag
// RULE4 - skip command answers skip only while flag is set
// RULE5 - read command drives column data to accumulator, clears flag
// RULE6 - alphanumeric select starts card, six-bit code per column
// RULE7 - binary select starts card, all twelve rows available
// RULE8 - binary needs two reads per column, upper half first
// RULE9 - each read gives six bits in accumulator bits 12 to 17
// RULE10 - binary reads: rows Y,X,0-3 first, then rows 4-9
// RULE11 - latest select sets mode, also mid-card for later columns
// RULE12 - flag drives interrupt request and status bit 9
// RULE13 - card done level on status bit 10
// RULE14 - fault on status bit 11, OR of six conditions
// RULE15 - end-of-file latched on bit 12 until reset switch
// RULE16 - respond only when six-bit device address matches
// RULE17 - skip produced on first command pulse
// RULE18 - unread column is overwritten and flag set again
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.svh"
module pcr_card_reader
	import pcr_pkg::*;
#(
	parameter logic [5:0] DEV_ADDR   = `PCR_DEV_ADDR,
	parameter int         COL_CYCLES = `PCR_COL_CYCLES
)
(
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic [5:0]  iot_addr_i,
	input  wire logic        iot_p1_i,
	input  wire logic        iot_p2_i,
	input  wire logic        iot_p4_i,
	input  wire logic        iot_mode_bit_i,
	input  wire logic [11:0] card_rows_i,
	input  wire logic [5:0]  card_alpha_i,
	input  wire logic        rdr_not_ready_i,
	input  wire logic        hopper_empty_i,
	input  wire logic        stacker_full_i,
	input  wire logic        card_jam_i,
	input  wire logic        validity_err_i,
	input  wire logic        validity_en_i,
	input  wire logic        circuit_fail_i,
	input  wire logic        eof_switch_i,
	input  wire logic        eof_reset_i,
	output logic             skip_o,
	output logic [17:0]      accumulator_o,
	output logic             accumulator_valid_o,
	output logic             program_interrupt_request_o,
	output logic [17:0]      status_o,
	output logic             card_motion_o
);
	// pins from the reader mechanism are asynchronous; two flops each
	logic [8:0]  pin_s1_reg;
	logic [8:0]  pin_s2_reg;
	logic        eof_reg;
	logic        flag_reg;
	logic        half_reg;
	logic        done_reg;
	pcr_mode_t   mode_reg;
	pcr_state_t  state_reg;
	logic        skip_reg;
	logic [17:0] acc_reg;
	logic        acc_valid_reg;
	logic [11:0] col_rows_reg;
	logic [5:0]  col_alpha_reg;
	logic        sel;
	logic        start;
	logic        busy;
	logic [11:0] rows_s1_reg;
	logic [11:0] rows_s2_reg;
	logic [5:0]  alpha_s1_reg;
	logic [5:0]  alpha_s2_reg;
	logic        not_ready_sync;
	logic        hopper_empty_sync;
	logic        stacker_full_sync;
	logic        card_jam_sync;
	logic        validity_err_sync;
	logic        validity_en_sync;
	logic        circuit_fail_sync;
	logic        eof_switch_sync;
	logic        eof_reset_sync;
	logic        fault;
	logic        skip_cmd;
	logic        read_cmd;
	logic        card_end;
	pcr_col_if   col ();

	function automatic logic [17:0] pcr_place(input logic [5:0] bits);
		pcr_place = 18'(bits); // RULE9
	endfunction

	// status word is numbered from the most significant end, bit 0 is [17]
	function automatic int unsigned pcr_st_pos(input int unsigned bit_no);
		pcr_st_pos = 17 - bit_no;
	endfunction

	// six bits per read: the alphanumeric code, or one half of the binary rows
	function automatic logic [5:0] pcr_pick(input pcr_mode_t mode, input logic half, input logic [11:0] rows,
		input logic [5:0] alpha);
		if (mode == PCR_MODE_ALPHA)
			pcr_pick = alpha; // RULE6
		else if (!half)
			pcr_pick = rows[11:6]; // RULE10
		else
			pcr_pick = rows[5:0]; // RULE10
	endfunction

	assign sel = (iot_addr_i == DEV_ADDR); // RULE16
	assign start = sel && iot_p4_i;
	assign skip_cmd = sel && iot_p1_i;
	assign read_cmd = sel && iot_p2_i;
	// the last column drops busy in the same cycle as its strobe
	assign card_end = !busy && col.strobe;

	// the pacer ignores a select while a card moves, so that select only changes the mode
	pcr_col_pacer #(
		.COL_CYCLES (COL_CYCLES)
	) u_pacer (
		.mclk_i  (mclk_i),
		.rstn_i  (rstn_i),
		.start_i (start),
		.rows_i  (rows_s2_reg),
		.alpha_i (alpha_s2_reg),
		.busy_o  (busy),
		.col     (col.src)
	);

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_s1_reg <= 9'h000;
			pin_s2_reg <= 9'h000;
		end
		else
		begin
			pin_s1_reg <= {rdr_not_ready_i, hopper_empty_i, stacker_full_i, card_jam_i,
				validity_err_i, validity_en_i, circuit_fail_i, eof_switch_i, eof_reset_i};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// card data is stable around each column instant, so a plain two-flop path is enough
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rows_s1_reg <= 12'h000;
			rows_s2_reg <= 12'h000;
			alpha_s1_reg <= 6'h00;
			alpha_s2_reg <= 6'h00;
		end
		else
		begin
			rows_s1_reg <= card_rows_i;
			rows_s2_reg <= rows_s1_reg;
			alpha_s1_reg <= card_alpha_i;
			alpha_s2_reg <= alpha_s1_reg;
		end
	end

	assign not_ready_sync = pin_s2_reg[8];
	assign hopper_empty_sync = pin_s2_reg[7];
	assign stacker_full_sync = pin_s2_reg[6];
	assign card_jam_sync = pin_s2_reg[5];
	assign validity_err_sync = pin_s2_reg[4];
	assign validity_en_sync = pin_s2_reg[3];
	assign circuit_fail_sync = pin_s2_reg[2];
	assign eof_switch_sync = pin_s2_reg[1];
	assign eof_reset_sync = pin_s2_reg[0];
	assign fault = not_ready_sync | hopper_empty_sync | stacker_full_sync | card_jam_sync
		| (validity_err_sync & validity_en_sync) | circuit_fail_sync; // RULE14

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			mode_reg <= PCR_MODE_ALPHA;
		else if (start)
			mode_reg <= iot_mode_bit_i ? PCR_MODE_BIN : PCR_MODE_ALPHA; // RULE6 RULE7 RULE11
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_reg <= PCR_IDLE;
		else
		begin
			unique case (state_reg)
				PCR_IDLE,
				PCR_DONE:
				begin
					if (start)
						state_reg <= PCR_FEED;
				end
				PCR_FEED:
				begin
					// a select in the last column's cycle starts the next card at once
					if (card_end)
						state_reg <= start ? PCR_FEED : PCR_DONE; // RULE1
				end
				default:
					state_reg <= PCR_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			done_reg <= 1'b0;
		else if (start)
			done_reg <= 1'b0;
		else if (state_reg == PCR_FEED && card_end)
			done_reg <= 1'b1; // RULE13
	end

	// the column buffer is simply overwritten when the host falls behind
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			col_rows_reg <= 12'h000;
			col_alpha_reg <= 6'h00;
		end
		else if (col.strobe)
		begin
			col_rows_reg <= col.rows; // RULE18
			col_alpha_reg <= col.alpha;
		end
	end

	// a new column wins over a same-cycle read clear
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			flag_reg <= 1'b0;
		else if (col.strobe)
			flag_reg <= 1'b1; // RULE2 RULE18
		else if (read_cmd && (mode_reg == PCR_MODE_ALPHA || half_reg))
			flag_reg <= 1'b0; // RULE5
	end

	// binary columns take two reads; the half pointer restarts with every column
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			half_reg <= 1'b0;
		else if (col.strobe)
			half_reg <= 1'b0;
		else if (read_cmd)
			half_reg <= (mode_reg == PCR_MODE_BIN) && !half_reg; // RULE8
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			acc_reg <= 18'h00000;
			acc_valid_reg <= 1'b0;
		end
		else
		begin
			acc_valid_reg <= read_cmd;
			if (read_cmd)
				acc_reg <= pcr_place(pcr_pick(mode_reg, half_reg, col_rows_reg, col_alpha_reg)); // RULE5 RULE9 RULE10
			else
				acc_reg <= 18'h00000;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			skip_reg <= 1'b0;
		else
			// answers from the flag as it stood before this pulse
			skip_reg <= skip_cmd && flag_reg; // RULE4 RULE17
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			eof_reg <= 1'b0;
		// a held switch outranks the reset switch
		else if (eof_switch_sync)
			eof_reg <= 1'b1; // RULE15
		else if (eof_reset_sync)
			eof_reg <= 1'b0;
	end

	assign skip_o = skip_reg;
	assign accumulator_o = acc_reg;
	assign accumulator_valid_o = acc_valid_reg;
	assign program_interrupt_request_o = flag_reg; // RULE12
	assign card_motion_o = busy;

	always_comb
	begin
		status_o = 18'h00000;
		status_o[pcr_st_pos(`PCR_ST_FLAG)] = flag_reg; // RULE12
		status_o[pcr_st_pos(`PCR_ST_DONE)] = done_reg; // RULE13
		status_o[pcr_st_pos(`PCR_ST_FAULT)] = fault; // RULE14
		status_o[pcr_st_pos(`PCR_ST_EOF)] = eof_reg; // RULE15
	end
endmodule
`default_nettype wire

// *** verif/pcr_card_reader_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcr_card_reader_properties
#(
	parameter logic [5:0] DEV_ADDR   = 6'h37,
	parameter int         COL_CYCLES = 20
)
(
	input wire logic        mclk_i,
	input wire logic        rstn_i,
	input wire logic [5:0]  iot_addr_i,
	input wire logic        iot_p1_i,
	input wire logic        iot_p2_i,
	input wire logic        iot_p4_i,
	input wire logic        card_jam_i,
	input wire logic        skip_o,
	input wire logic [17:0] accumulator_o,
	input wire logic        accumulator_valid_o,
	input wire logic        program_interrupt_request_o,
	input wire logic [17:0] status_o,
	input wire logic        card_motion_o
);
	wire logic pir = program_interrupt_request_o;
	wire logic hit = iot_addr_i == DEV_ADDR;
	logic      seen;
	logic      pir_q;
	int        gap;
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);
	// an unread column gives no rise, so gaps are compared as multiples of the column period
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			{seen, pir_q, gap} <= '0;
		else
		begin
			pir_q <= pir;
			gap   <= (pir && !pir_q) ? 0 : gap + 1;
			if (iot_p4_i && hit && !card_motion_o)
				seen <= 1'b0;
			else if (pir && !pir_q)
				seen <= 1'b1;
		end
	end
	sequence s_cmd(p); p && hit; endsequence
	sequence s_jam; card_jam_i [*5]; endsequence
	property p_skip_set; s_cmd(iot_p1_i) ##0 pir |=> skip_o; endproperty
	a_skip_set: assert property (p_skip_set) else $error("skip missing");
	property p_skip_why; skip_o |-> $past(iot_p1_i && pir && hit); endproperty
	a_skip_why: assert property (p_skip_why) else $error("stray skip");
	property p_foreign; (iot_p1_i || iot_p2_i || iot_p4_i) && !hit |=> !skip_o && !accumulator_valid_o; endproperty
	a_foreign: assert property (p_foreign) else $error("foreign answered");
	property p_read; s_cmd(iot_p2_i) |=> accumulator_valid_o; endproperty
	a_read: assert property (p_read) else $error("read missing");
	property p_width; accumulator_valid_o |-> accumulator_o[17:6] == 12'h000; endproperty
	a_width: assert property (p_width) else $error("wide read");
	property p_select; s_cmd(iot_p4_i) |=> card_motion_o; endproperty
	a_select: assert property (p_select) else $error("no motion");
	property p_fault; s_jam |-> status_o[6]; endproperty
	a_fault: assert property (p_fault) else $error("fault missing");
	property p_space; pir && !pir_q && seen |-> (gap + 1) % COL_CYCLES == 0; endproperty
	a_space: assert property (p_space) else $error("column spacing");
endmodule
bind pcr_card_reader pcr_card_reader_properties #(.DEV_ADDR(DEV_ADDR), .COL_CYCLES(COL_CYCLES)) u_props (
	.mclk_i, .rstn_i, .iot_addr_i, .iot_p1_i, .iot_p2_i, .iot_p4_i, .card_jam_i, .skip_o, .accumulator_o,
	.accumulator_valid_o, .program_interrupt_request_o, .status_o, .card_motion_o);
`default_nettype wire

// *** verif/pcr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model
(
	input  wire logic  mclk_i,
	output logic [5:0] addr_o,
	output logic [3:0] sub_o
);
	initial {addr_o, sub_o} = '0;
	// afterwards the address is inverted so a stale match cannot pass
	task automatic cmd(input logic [5:0] a, input logic [5:0] s);
		@(posedge mclk_i);
		{addr_o, sub_o} <= {a, s[3:0]};
		@(posedge mclk_i);
		{addr_o, sub_o} <= {~a, 4'h0};
	endtask
endmodule
`default_nettype wire

// *** verif/pcr_card_reader_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.svh"
module pcr_card_reader_tb;
	localparam int         COLS      = 20;
	localparam logic [7:0] FROWS [8] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'h10, 8'hB0, 8'hC0, 8'h00};
	logic        mclk_i     = 1'b0;
	logic        rstn_i     = 1'b0;
	logic [11:0] rows       = 12'hA5C;
	logic [5:0]  alpha      = 6'h2B;
	logic [6:0]  flt        = 7'h00;
	logic [1:0]  eof        = 2'b00;
	logic [5:0]  addr;
	logic [3:0]  sub;
	logic [17:0] acc;
	logic [17:0] st;
	logic        skip, accv, pir, mot;
	int          mismatches = 0;
	int          compares   = 0;
	always #2 mclk_i = ~mclk_i;
	pcr_host_model host (.mclk_i, .addr_o(addr), .sub_o(sub));
	pcr_card_reader #(.COL_CYCLES(COLS)) DUT (.mclk_i, .rstn_i, .iot_addr_i(addr), .iot_p1_i(sub[0]),
		.iot_p2_i(sub[1]), .iot_p4_i(sub[2]), .iot_mode_bit_i(sub[3]), .card_rows_i(rows), .card_alpha_i(alpha),
		.rdr_not_ready_i(flt[0]), .hopper_empty_i(flt[1]), .stacker_full_i(flt[2]), .card_jam_i(flt[3]),
		.validity_err_i(flt[4]), .validity_en_i(flt[5]), .circuit_fail_i(flt[6]), .eof_switch_i(eof[0]),
		.eof_reset_i(eof[1]), .skip_o(skip), .accumulator_o(acc), .accumulator_valid_o(accv),
		.program_interrupt_request_o(pir), .status_o(st), .card_motion_o(mot));
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk(18'(got), 18'(exp));
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic cmd(input logic [5:0] s);
		host.cmd(`PCR_DEV_ADDR, s);
		#1;
	endtask
	task automatic wait_flag;
		for (int n = 0; n < 2 * COLS && pir !== 1'b1; n++)
			ticks(1);
		chkb(pir, 1'b1);
	endtask
	task automatic eof_pulse(input logic [1:0] v);
		@(posedge mclk_i);
		eof <= v;
		ticks(6);
		@(posedge mclk_i);
		eof <= 2'b00;
		ticks(6);
	endtask
	task automatic summarize;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		ticks(1);
		chk(st, 18'h0);
		chk({14'h0, skip, accv, pir, mot}, 18'h0);
		$display("done reset");
		foreach (FROWS[i])
		begin
			@(posedge mclk_i);
			flt <= FROWS[i][6:0];
			ticks(6);
			chkb(st[6], FROWS[i][7]);
		end
		$display("done fault table");
		cmd(`PCR_SUB_SKIP);
		chkb(skip, 1'b0);
		cmd(`PCR_SUB_SEL_ALPHA);
		chkb(mot, 1'b1);
		wait_flag();
		chkb(st[8], 1'b1);
		host.cmd(6'h36, `PCR_SUB_SKIP);
		#1 chkb(skip, 1'b0);
		cmd(`PCR_SUB_SKIP);
		chkb(skip, 1'b1);
		cmd(`PCR_SUB_READ);
		chk(acc, 18'h0002B);
		chkb(pir, 1'b0);
		cmd(`PCR_SUB_SEL_BIN);
		wait_flag();
		cmd(`PCR_SUB_READ);
		chk(acc, {12'h000, rows[11:6]});
		chkb(pir, 1'b1);
		cmd(`PCR_SUB_READ);
		chk(acc, {12'h000, rows[5:0]});
		$display("done modes");
		wait_flag();
		@(posedge mclk_i);
		rows <= 12'h5A6;
		ticks(COLS);
		cmd(`PCR_SUB_READ);
		chk(acc, 18'h00016);
		cmd(`PCR_SUB_READ);
		chk(acc, 18'h00026);
		$display("done overrun");
		repeat (76)
		begin
			wait_flag();
			cmd(`PCR_SUB_READ);
			cmd(`PCR_SUB_READ);
		end
		chkb(mot, 1'b0);
		chkb(st[7], 1'b1);
		$display("done card");
		eof_pulse(2'b01);
		chkb(st[5], 1'b1);
		eof_pulse(2'b10);
		chkb(st[5], 1'b0);
		$display("done eof");
		summarize();
	end
	initial
	begin
		#40000;
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
